// >>> dpi_pkg.sv
// Shared types and constants of the display panel interface block.
// Assumes a single core clock; all settings arrive as static ports from software.
package dpi_pkg;

  // Widths of the programmable fields and the write queue depth
  localparam int DPI_CNT_W    = 8;
  localparam int DPI_LINE_W   = 12;
  localparam int DPI_WORD_W   = 16;
  localparam int DPI_PRE_W    = 5;
  localparam int DPI_FIFO_D   = 16;

  // Reset values, idle levels and the preamble length limit
  localparam logic [DPI_WORD_W-1:0] DPI_WORD_RST = 16'h0000;
  localparam logic [DPI_CNT_W-1:0]  DPI_CNT_RST  = 8'h00;
  localparam logic [DPI_LINE_W-1:0] DPI_LINE_RST = 12'h000;
  localparam logic [DPI_PRE_W-1:0]  DPI_PRE_MAX  = 5'h10;
  localparam logic [1:0]            DPI_CS_IDLE  = 2'h3;

  // Serial panel wiring variants
  typedef enum logic [1:0] {
    DPI_MODE_3W     = 2'b00,
    DPI_MODE_4W     = 2'b01,
    DPI_MODE_5W_CLK = 2'b10,
    DPI_MODE_5W_CS  = 2'b11
  } dpi_mode_e;

  // Serial transfer phases
  typedef enum logic [2:0] {
    DPI_ST_IDLE  = 3'b000,
    DPI_ST_SETUP = 3'b001,
    DPI_ST_PRE   = 3'b010,
    DPI_ST_HDR   = 3'b011,
    DPI_ST_DATA  = 3'b100,
    DPI_ST_DONE  = 3'b101
  } dpi_state_e;

  // Pixel-level timing of the synchronous panel
  typedef struct packed {
    logic [DPI_CNT_W-1:0]  pixel_clock_divider;
    logic [DPI_LINE_W-1:0] line_pixel_count;
    logic [DPI_CNT_W-1:0]  hsync_width;
    logic [DPI_LINE_W-1:0] frame_line_count;
    logic [DPI_CNT_W-1:0]  vsync_width;
  } dpi_sync_timing_s;

  // Per-panel serial framing settings
  typedef struct packed {
    dpi_mode_e            mode;
    logic [DPI_PRE_W-1:0] preamble_len;
    logic [DPI_WORD_W-1:0] preamble;
    logic                 rw_enable;
    logic                 rs_first;
    logic [3:0]           word_len_m1;
  } dpi_serial_panel_config_s;

  // Per-panel access timing, in fast clock ticks
  typedef struct packed {
    logic [DPI_CNT_W-1:0] write_cycle_period;
    logic [DPI_CNT_W-1:0] read_cycle_period;
    logic [DPI_CNT_W-1:0] write_strobe_fall_point;
    logic [DPI_CNT_W-1:0] write_strobe_rise_point;
    logic [DPI_CNT_W-1:0] read_strobe_fall_point;
    logic [DPI_CNT_W-1:0] read_strobe_rise_point;
    logic [DPI_CNT_W-1:0] read_sample_point;
  } dpi_panel_access_timing_s;

endpackage

// >>> dpi_fifo.sv
// Synchronous FIFO with valid/ready on both sides and registered flags.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module dpi_fifo
  import dpi_pkg::*;
#(
  parameter int WIDTH = DPI_WORD_W,
  parameter int DEPTH = DPI_FIFO_D
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_nrst,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output var  logic             o_in_ready,
  output var  logic             o_out_valid,
  output var  logic [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  // Pointers wrap naturally, so the depth must be a power of two
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("dpi_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;
  logic [AW:0]      next_count;

  assign push       = i_in_valid && o_in_ready;
  assign pop        = o_out_valid && i_out_ready;
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  assign o_out_data = mem[rd_ptr];

  // Storage has no reset; only pointers, count and flags carry state
  always_ff @(posedge i_core_clk) begin
    if (push) mem[wr_ptr] <= i_in_data;
  end

  // Flags registered from the next count so ready never depends on the drain side combinationally
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      wr_ptr      <= '0;
      rd_ptr      <= '0;
      count       <= '0;
      o_in_ready  <= 1'b0;
      o_out_valid <= 1'b0;
    end else begin
      wr_ptr      <= wr_ptr + AW'(push);
      rd_ptr      <= rd_ptr + AW'(pop);
      count       <= next_count;
      o_in_ready  <= next_count != (AW+1)'(DEPTH);
      o_out_valid <= next_count != '0;
    end
  end
endmodule // dpi_fifo
`default_nettype wire

// >>> dpi_display_if.sv
// Display panel interface: synchronous pixel timing plus a serial panel link.
// Assumes static settings from software and a panel that keeps its own timing.
`timescale 1ns/10ps
`default_nettype none

module dpi_display_if
  import dpi_pkg::*;
#(
  parameter int FIFO_DEPTH = DPI_FIFO_D
) (
  input  wire logic                     i_core_clk,
  input  wire logic                     i_nrst,
  // Synchronous panel
  input  wire logic                     i_sync_en,
  input  wire dpi_sync_timing_s         i_sync_timing,
  output var  logic                     o_pix_clk,
  output var  logic                     o_hsync_n,
  output var  logic                     o_vsync_n,
  output var  logic                     o_data_en,
  // Serial panel settings, index is the panel
  input  wire dpi_serial_panel_config_s [1:0] i_serial_panel_config,
  input  wire dpi_panel_access_timing_s [1:0] i_panel_access_timing,
  input  wire logic [DPI_CNT_W-1:0]     i_fast_clock_period_setting,
  // Write words
  input  wire logic                     i_wr_valid,
  input  wire logic [DPI_WORD_W-1:0]    i_wr_data,
  output var  logic                     o_wr_ready,
  // Transfer command
  input  wire logic                     i_xfer_start,
  input  wire logic                     i_xfer_panel,
  input  wire logic                     i_xfer_read,
  input  wire logic                     i_xfer_rs,
  input  wire logic                     i_xfer_burst,
  output var  logic                     o_busy,
  output var  logic [DPI_WORD_W-1:0]    o_rd_data,
  output var  logic                     o_rd_valid,
  // Serial pins
  output var  logic                     o_serial_shift_clock,
  output var  logic                     o_serial_out_line,
  output var  logic                     o_serial_out_drive_enable,
  input  wire logic                     i_serial_in_line,
  output var  logic [1:0]               o_panel_chip_select_n,
  output var  logic                     o_register_select_bit
);

  initial begin
    if (FIFO_DEPTH < 2) $error("dpi_display_if: FIFO_DEPTH must be at least 2");
  end

  // ---------------- Synchronous pixel timing ----------------
  logic [DPI_CNT_W-1:0]  pix_div;
  logic [DPI_LINE_W-1:0] pix_cnt;
  logic [DPI_LINE_W-1:0] line_cnt;
  logic                  pix_tick;
  logic                  line_end;
  logic                  frame_end;

  assign pix_tick  = pix_div == i_sync_timing.pixel_clock_divider;
  assign line_end  = pix_tick && pix_cnt == i_sync_timing.line_pixel_count;
  assign frame_end = line_end && line_cnt == i_sync_timing.frame_line_count;

  // Divider, pixel and line counters; disabled timing parks everything at zero
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst || !i_sync_en) begin
      pix_div  <= DPI_CNT_RST;
      pix_cnt  <= DPI_LINE_RST;
      line_cnt <= DPI_LINE_RST;
    end else begin
      pix_div  <= pix_tick ? DPI_CNT_RST : pix_div + 8'h01;
      pix_cnt  <= line_end ? DPI_LINE_RST : pix_cnt + 12'(pix_tick);
      line_cnt <= frame_end ? DPI_LINE_RST : line_cnt + 12'(line_end);
    end
  end

  // Pins follow the counters one cycle late, uniformly, so widths are unaffected
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst || !i_sync_en) begin
      o_pix_clk <= 1'b0;
      o_hsync_n <= 1'b1;
      o_vsync_n <= 1'b1;
      o_data_en <= 1'b0;
    end else begin
      o_pix_clk <= pix_div > (i_sync_timing.pixel_clock_divider >> 1);
      o_hsync_n <= !(pix_cnt <= 12'(i_sync_timing.hsync_width));
      o_vsync_n <= !(line_cnt <= 12'(i_sync_timing.vsync_width));
      o_data_en <= pix_cnt > 12'(i_sync_timing.hsync_width) && line_cnt > 12'(i_sync_timing.vsync_width);
    end
  end

  // ---------------- Serial panel link ----------------
  logic                     fifo_valid;
  logic [DPI_WORD_W-1:0]    fifo_data;
  logic                     fifo_pop;

  // Write words queue here so software can run ahead of a slow panel
  dpi_fifo #(
    .WIDTH (DPI_WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk  (i_core_clk),
    .i_nrst      (i_nrst),
    .i_in_valid  (i_wr_valid),
    .i_in_data   (i_wr_data),
    .o_in_ready  (o_wr_ready),
    .o_out_valid (fifo_valid),
    .o_out_data  (fifo_data),
    .i_out_ready (fifo_pop)
  );

  // Serial input comes from a pin: two flops before use
  logic sd_in_meta;
  logic sd_in;
  always_ff @(posedge i_core_clk) begin
    sd_in_meta <= i_serial_in_line;
    sd_in      <= sd_in_meta;
  end

  dpi_state_e               state;
  dpi_state_e               next_state;
  logic                     panel;
  logic                     rd;
  logic                     rs;
  logic                     burst;
  logic [DPI_CNT_W-1:0]     fast_div;
  logic [DPI_CNT_W-1:0]     bit_cnt;
  logic [DPI_WORD_W-1:0]    tx;
  logic [DPI_WORD_W-1:0]    rx;
  logic [DPI_PRE_W-1:0]     rem;
  dpi_serial_panel_config_s cfg;
  dpi_panel_access_timing_s tim;
  logic                     five_wire;
  logic [1:0]               hdr_n;
  logic [1:0]               hdr_bits;
  logic [DPI_PRE_W-1:0]     pre_n;
  logic                     rd_phase;
  logic [DPI_CNT_W-1:0]     cur_per;
  logic [DPI_CNT_W-1:0]     cur_fall;
  logic [DPI_CNT_W-1:0]     cur_rise;
  logic                     fast_tick;
  logic                     bit_end;
  logic                     shifting;
  logic                     last_bit;
  logic                     start_ok;
  logic [DPI_WORD_W-1:0]    next_rx;
  logic                     next_tx_out;

  // Settings of the selected panel, chosen per transfer
  assign cfg       = i_serial_panel_config[panel];
  assign tim       = i_panel_access_timing[panel];
  assign five_wire = cfg.mode == DPI_MODE_5W_CLK || cfg.mode == DPI_MODE_5W_CS;
  assign pre_n     = cfg.preamble_len > DPI_PRE_MAX ? DPI_PRE_MAX : cfg.preamble_len;

  // Header: direction bit may be dropped; 5-wire carries select on its own line
  assign hdr_n    = 2'(cfg.rw_enable) + 2'(!five_wire);
  assign hdr_bits = (hdr_n == 2'h2) ? (cfg.rs_first ? {rs, rd} : {rd, rs})
                  : {(cfg.rw_enable ? rd : rs), 1'b0};

  // Read data bits use the read timing set, all other bits the write set
  assign rd_phase  = state == DPI_ST_DATA && rd;
  assign cur_per   = rd_phase ? tim.read_cycle_period : tim.write_cycle_period;
  assign cur_fall  = rd_phase ? tim.read_strobe_fall_point : tim.write_strobe_fall_point;
  assign cur_rise  = rd_phase ? tim.read_strobe_rise_point : tim.write_strobe_rise_point;
  assign fast_tick = fast_div == i_fast_clock_period_setting;
  assign bit_end   = fast_tick && bit_cnt == cur_per;
  assign shifting  = state == DPI_ST_PRE || state == DPI_ST_HDR || state == DPI_ST_DATA;
  assign last_bit  = bit_end && (state == DPI_ST_SETUP || rem <= 5'h01);
  assign start_ok  = i_xfer_start && (i_xfer_read || fifo_valid);
  assign next_rx   = (fast_tick && rd_phase && bit_cnt == tim.read_sample_point) ? {rx[14:0], sd_in} : rx;

  // Phase order: preamble, header, data words, then release
  always_comb begin
    next_state = state;
    unique case (state)
      DPI_ST_IDLE:  if (start_ok) next_state = DPI_ST_SETUP;
      DPI_ST_SETUP: if (last_bit) next_state = pre_n != '0 ? DPI_ST_PRE
                                             : (hdr_n != 2'h0 ? DPI_ST_HDR : DPI_ST_DATA);
      DPI_ST_PRE:   if (last_bit) next_state = hdr_n != 2'h0 ? DPI_ST_HDR : DPI_ST_DATA;
      DPI_ST_HDR:   if (last_bit) next_state = DPI_ST_DATA;
      DPI_ST_DATA:  if (last_bit) next_state = (burst && !rd && fifo_valid) ? DPI_ST_DATA : DPI_ST_DONE;
      DPI_ST_DONE:  next_state = DPI_ST_IDLE;
      default:      next_state = DPI_ST_IDLE;
    endcase
  end

  // A write word leaves the queue exactly when its first bit is loaded
  assign fifo_pop    = last_bit && next_state == DPI_ST_DATA && !rd;
  assign next_tx_out = tx[15];

  // Command capture and phase state
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      state <= DPI_ST_IDLE;
      panel <= 1'b0;
      rd    <= 1'b0;
      rs    <= 1'b0;
      burst <= 1'b0;
    end else begin
      state <= next_state;
      if (state == DPI_ST_IDLE && start_ok) begin
        panel <= i_xfer_panel;
        rd    <= i_xfer_read;
        rs    <= i_xfer_rs;
        burst <= i_xfer_burst;
      end
    end
  end

  // Fast clock prescaler and position inside the current bit
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst || state == DPI_ST_IDLE) begin
      fast_div <= DPI_CNT_RST;
      bit_cnt  <= DPI_CNT_RST;
    end else begin
      fast_div <= fast_tick ? DPI_CNT_RST : fast_div + 8'h01;
      bit_cnt  <= bit_end ? DPI_CNT_RST : bit_cnt + 8'(fast_tick);
    end
  end

  // Shift register: the bit on the line is always the top of tx
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      tx  <= DPI_WORD_RST;
      rem <= '0;
      rx  <= DPI_WORD_RST;
    end else begin
      rx <= next_rx;
      if (last_bit) begin
        rem <= '0;
        tx  <= DPI_WORD_RST;
        unique case (next_state)
          DPI_ST_PRE: begin
            tx  <= cfg.preamble << (5'h10 - pre_n);
            rem <= pre_n;
          end
          DPI_ST_HDR: begin
            tx  <= {hdr_bits, 14'h0000};
            rem <= 5'(hdr_n);
          end
          DPI_ST_DATA: begin
            tx  <= rd ? DPI_WORD_RST : fifo_data << (4'hf - cfg.word_len_m1);
            rem <= 5'(cfg.word_len_m1) + 5'h01;
            rx  <= DPI_WORD_RST;
          end
          default: begin
          end
        endcase
      end else if (bit_end && shifting) begin
        tx  <= tx << 1;
        rem <= rem - 5'h01;
      end
    end
  end

  // Read word hand-off, a one-cycle strobe after the last data bit
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_rd_data  <= DPI_WORD_RST;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= rd_phase && last_bit;
      if (rd_phase && last_bit) o_rd_data <= next_rx;
    end
  end

  // Pin drivers; chip select spans the preamble through the last data bit
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_busy                    <= 1'b0;
      o_serial_shift_clock      <= 1'b1;
      o_serial_out_line         <= 1'b0;
      o_serial_out_drive_enable <= 1'b0;
      o_panel_chip_select_n     <= DPI_CS_IDLE;
      o_register_select_bit     <= 1'b0;
    end else begin
      o_busy <= next_state != DPI_ST_IDLE;
      // Clock low between fall and rise points of the bit; panel samples on the rise
      o_serial_shift_clock <= !(shifting && bit_cnt >= cur_fall && bit_cnt < cur_rise);
      o_serial_out_line    <= shifting ? next_tx_out : 1'b0;
      // 3-wire turns the shared line round for read data; 4/5-wire never switch
      if (cfg.mode == DPI_MODE_3W) begin
        o_serial_out_drive_enable <= (state != DPI_ST_IDLE && state != DPI_ST_DONE) && !rd_phase;
      end else begin
        o_serial_out_drive_enable <= 1'b1;
      end
      o_panel_chip_select_n <= DPI_CS_IDLE;
      if (shifting) o_panel_chip_select_n[panel] <= 1'b0;
      // Select line: set before chip select for the CS-sampled variant,
      // with the first shifted bit for the clock-sampled variant
      if (state == DPI_ST_IDLE) begin
        o_register_select_bit <= 1'b0;
      end else if (cfg.mode == DPI_MODE_5W_CS && state == DPI_ST_SETUP) begin
        o_register_select_bit <= rs;
      end else if (cfg.mode == DPI_MODE_5W_CLK && shifting) begin
        o_register_select_bit <= rs;
      end
    end
  end

endmodule // dpi_display_if
`default_nettype wire

// >>> dpi_display_if_asserts.sv
// Port checks for the display interface, bound into dpi_display_if.
// Assumes one core clock and its synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module dpi_display_if_asserts
  import dpi_pkg::*;
(
  input wire logic                           i_core_clk,
  input wire logic                           i_nrst,
  input wire logic                           i_sync_en,
  input wire dpi_sync_timing_s               i_sync_timing,
  input wire logic                           o_pix_clk,
  input wire logic                           o_hsync_n,
  input wire dpi_serial_panel_config_s [1:0] i_serial_panel_config,
  input wire logic                           i_xfer_start,
  input wire logic                           i_xfer_read,
  input wire logic                           o_busy,
  input wire logic                           o_rd_valid,
  input wire logic                           o_serial_shift_clock,
  input wire logic                           o_serial_out_drive_enable,
  input wire logic [1:0]                     o_panel_chip_select_n,
  input wire logic                           o_register_select_bit
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  logic [15:0] pix_n;
  logic [15:0] line_n;
  logic        pix_v;
  logic        line_v;
  // Cycles since the last pixel clock rise and line start; trusted only after one full mark
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst || !i_sync_en) begin
      pix_n  <= 16'h0001;
      line_n <= 16'h0001;
      pix_v  <= 1'b0;
      line_v <= 1'b0;
    end else begin
      pix_n  <= $rose(o_pix_clk) ? 16'h0001 : pix_n + 16'h0001;
      line_n <= $fell(o_hsync_n) ? 16'h0001 : line_n + 16'h0001;
      pix_v  <= pix_v | $rose(o_pix_clk);
      line_v <= line_v | $fell(o_hsync_n);
    end
  end
  // A read command accepted while idle
  sequence s_read_take;
    i_xfer_start && i_xfer_read && !o_busy;
  endsequence
  // Three idle cycles in a row
  sequence s_idle3;
    !o_busy [*3];
  endsequence
  reset_idle_a: assert property (disable iff (1'b0) !i_nrst |=>
    o_panel_chip_select_n == DPI_CS_IDLE && !o_busy && o_serial_shift_clock && !o_serial_out_drive_enable)
    else $error("serial pins not idle after reset");
  pix_period_a: assert property ($rose(o_pix_clk) && pix_v |->
    pix_n == i_sync_timing.pixel_clock_divider + 16'h0001) else $error("pixel clock period wrong");
  line_len_a: assert property ($fell(o_hsync_n) && line_v |-> line_n ==
    (i_sync_timing.line_pixel_count + 16'h0001) * (i_sync_timing.pixel_clock_divider + 16'h0001))
    else $error("line length wrong");
  hsync_width_a: assert property ($rose(o_hsync_n) && line_v |-> line_n ==
    (i_sync_timing.hsync_width + 16'h0001) * (i_sync_timing.pixel_clock_divider + 16'h0001))
    else $error("line sync width wrong");
  start_busy_a: assert property (s_read_take |=> o_busy) else $error("read command not taken");
  rd_pulse_a: assert property (o_rd_valid |=> !o_rd_valid) else $error("read valid too long");
  one_panel_a: assert property (o_panel_chip_select_n != 2'h0) else $error("both panels selected");
  idle_bus_a: assert property (s_idle3 |-> o_serial_shift_clock && o_panel_chip_select_n == DPI_CS_IDLE)
    else $error("serial bus active while idle");
  drive_4w_a: assert property ($past(i_nrst) && $stable(i_serial_panel_config) &&
    i_serial_panel_config[0].mode != DPI_MODE_3W && i_serial_panel_config[1].mode != DPI_MODE_3W
    |-> o_serial_out_drive_enable) else $error("separate out line not driven");
  rs_setup_a: assert property ($fell(o_panel_chip_select_n[0]) &&
    i_serial_panel_config[0].mode == DPI_MODE_5W_CS |-> $stable(o_register_select_bit))
    else $error("select bit moved at chip select");
endmodule // dpi_display_if_asserts
bind dpi_display_if dpi_display_if_asserts u_dpi_chk (
  .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_sync_en(i_sync_en), .i_sync_timing(i_sync_timing),
  .o_pix_clk(o_pix_clk), .o_hsync_n(o_hsync_n), .i_serial_panel_config(i_serial_panel_config),
  .i_xfer_start(i_xfer_start), .i_xfer_read(i_xfer_read), .o_busy(o_busy), .o_rd_valid(o_rd_valid),
  .o_serial_shift_clock(o_serial_shift_clock), .o_serial_out_drive_enable(o_serial_out_drive_enable),
  .o_panel_chip_select_n(o_panel_chip_select_n), .o_register_select_bit(o_register_select_bit)
);
`default_nettype wire

// >>> dpi_panel_model.sv
// Behavioural serial panel: records shifted bits and answers reads.
// Assumes shift clock idling high and active-low chip selects.
`timescale 1ns/10ps
`default_nettype none
module dpi_panel_model #(
  parameter int CLK_NS = 40
) (
  input  wire logic        i_sclk,
  input  wire logic        i_sout,
  input  wire logic [1:0]  i_cs_n,
  input  wire logic        i_rs,
  input  wire logic        i_rd,
  input  var  int          i_lead,
  input  var  int          i_wl,
  input  wire logic [15:0] i_rd_word,
  output var  logic        o_sdata
);
  logic       q[$];
  logic [1:0] cs_seen;
  logic       rs_cs;
  logic       rs_clk;
  int         k;
  int         per;
  time        t;
  wire        sel = ~&i_cs_n;
  initial o_sdata = 1'b0;
  // Frame start: clear the record, note which panel and the select level
  always @(posedge sel) begin
    q = {};
    k = 0;
    cs_seen = i_cs_n;
    rs_cs = i_rs;
  end
  // Released line flips, so a stale bit never passes for data
  always @(negedge sel) o_sdata = ~o_sdata;
  // Read bits change on the falling shift clock, giving the device the high phase to sample
  always @(negedge i_sclk) begin
    if (sel && i_rd && k >= i_lead && k < i_lead + i_wl) o_sdata = i_rd_word[i_wl - 1 - (k - i_lead)];
  end
  // Rising shift clock takes the device's bit
  always @(posedge i_sclk) begin
    if (sel) begin
      if (k == 0) rs_clk = i_rs;
      else per = int'(($time - t) / CLK_NS);
      t = $time;
      if (!i_rd || k < i_lead) q.push_back(i_sout);
      k++;
    end
  end
endmodule // dpi_panel_model
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the display interface against a serial panel model.
// Assumes the checker and the panel model are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import dpi_pkg::*;
;
  logic                           clk, nrst, sync_en, wr_valid, start, panel, rd, rs, burst, sin, sdata;
  logic                           pclk, hs_n, vs_n, den, wr_ready, busy, rd_valid, sclk, sout, oe, rsb;
  logic [15:0]                    wr_data, rd_word, rd_data;
  logic [1:0]                     cs_n;
  logic [7:0]                     fast;
  dpi_sync_timing_s               st;
  dpi_serial_panel_config_s [1:0] cfg;
  dpi_panel_access_timing_s [1:0] acc;
  int                             failures, check_count, lead, wl, seed, n, lo, per, ln;
  logic                           eq[$];
  logic [15:0]                    wq[$];
  // Shared 3-wire pin: device bit while it drives, otherwise the panel's
  assign sin = (cfg[panel].mode == DPI_MODE_3W && oe) ? sout : sdata;
  dpi_display_if dut (
    .i_core_clk(clk), .i_nrst(nrst), .i_sync_en(sync_en), .i_sync_timing(st), .o_pix_clk(pclk),
    .o_hsync_n(hs_n), .o_vsync_n(vs_n), .o_data_en(den), .i_serial_panel_config(cfg),
    .i_panel_access_timing(acc), .i_fast_clock_period_setting(fast), .i_wr_valid(wr_valid),
    .i_wr_data(wr_data), .o_wr_ready(wr_ready), .i_xfer_start(start), .i_xfer_panel(panel),
    .i_xfer_read(rd), .i_xfer_rs(rs), .i_xfer_burst(burst), .o_busy(busy), .o_rd_data(rd_data),
    .o_rd_valid(rd_valid), .o_serial_shift_clock(sclk), .o_serial_out_line(sout),
    .o_serial_out_drive_enable(oe), .i_serial_in_line(sin), .o_panel_chip_select_n(cs_n),
    .o_register_select_bit(rsb));
  dpi_panel_model pm (
    .i_sclk(sclk), .i_sout(sout), .i_cs_n(cs_n), .i_rs(rsb), .i_rd(rd), .i_lead(lead),
    .i_wl(wl), .i_rd_word(rd_word), .o_sdata(sdata));
  // 25 MHz core clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Inputs always move 2 ns after the rising edge
  task automatic step(input int c = 1);
    repeat (c) @(posedge clk);
    #2;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic hang(input int k, input int lim);
    if (k >= lim) begin
      failures++;
      $display("unexpected at %0t: wait ran out", $time);
      final_report;
    end
  endtask
  // Queue one word; valid stays up between writes
  task automatic wr(input logic [15:0] d);
    int k;
    wr_valid = 1'b1;
    wr_data = d;
    for (k = 0; k < 100 && wr_ready !== 1'b1; k++) step;
    hang(k, 100);
    wq.push_back(d);
    step;
  endtask
  // One transfer: build the expected stream from the settings, run it, compare
  task automatic xfer(input logic p, input logic r, input int nw, input logic b);
    int          k;
    int          t;
    logic [15:0] d;
    logic [15:0] got;
    eq = {};
    got = 'x;
    t = 0;
    for (int i = 0; i < nw; i++) wr(16'($random(seed)));
    wr_valid = 1'b0;
    for (int i = int'(cfg[p].preamble_len) - 1; i >= 0; i--) eq.push_back(cfg[p].preamble[i]);
    rs = 1'($random(seed));
    if (cfg[p].rs_first && !cfg[p].mode[1]) eq.push_back(rs);
    if (cfg[p].rw_enable) eq.push_back(r);
    if (!cfg[p].rs_first && !cfg[p].mode[1]) eq.push_back(rs);
    lead = eq.size();
    wl = int'(cfg[p].word_len_m1) + 1;
    while (wq.size() > 0) begin
      d = wq.pop_front();
      for (int i = wl - 1; i >= 0; i--) eq.push_back(d[i]);
    end
    panel = p;
    rd = r;
    burst = b;
    rd_word = 16'($random(seed));
    step(2);
    start = 1'b1;
    step;
    start = 1'b0;
    chk(busy, 1'b1);
    for (k = 0; k < 4000 && t < 4; k++) begin
      step;
      if (rd_valid === 1'b1) got = rd_data;
      if (busy !== 1'b1) t++;
    end
    hang(k, 4000);
    chk(pm.q.size(), eq.size());
    foreach (eq[i]) chk(pm.q[i], eq[i]);
    chk(pm.cs_seen, {~p, p});
    chk(pm.per, (acc[p].write_cycle_period + 1) * (fast + 1));
    if (r) chk(got & 16'((1 << wl) - 1), rd_word & 16'((1 << wl) - 1));
    if (cfg[p].mode == DPI_MODE_5W_CLK) chk(pm.rs_clk, rs);
    if (cfg[p].mode == DPI_MODE_5W_CS) chk(pm.rs_cs, rs);
  endtask
  // Time one vertical sync pulse and one frame in core cycles
  task automatic span;
    int k;
    for (k = 0; k < 600 && vs_n !== 1'b1; k++) step;
    for (k = 0; k < 600 && vs_n !== 1'b0; k++) step;
    for (lo = 0; lo < 600 && vs_n === 1'b0; lo++) step;
    for (per = lo; per < 600 && vs_n === 1'b1; per++) step;
  endtask
  // Main sequence
  initial begin
    {nrst, sync_en, wr_valid, start, panel, rd, rs, burst, wr_data, rd_word, lead, wl} = '0;
    {failures, check_count} = '0;
    seed = 32'h7f50e58c;
    st = '{8'h03, 12'h009, 8'h01, 12'h005, 8'h00};
    fast = 8'h01;
    acc[0] = '{8'h05, 8'h05, 8'h01, 8'h03, 8'h01, 8'h03, 8'h04};
    acc[1] = '{8'h07, 8'h07, 8'h02, 8'h05, 8'h02, 8'h05, 8'h06};
    cfg[0] = '{DPI_MODE_3W, 5'h03, 16'h0005, 1'b1, 1'b0, 4'h7};
    cfg[1] = '{DPI_MODE_4W, 5'h00, 16'h0000, 1'b1, 1'b1, 4'h3};
    step(6);
    chk({cs_n, busy, sclk, oe, wr_ready, hs_n}, {DPI_CS_IDLE, 5'b01001});
    nrst = 1'b1;
    step(2);
    sync_en = 1'b1;
    ln = (st.line_pixel_count + 1) * (st.pixel_clock_divider + 1);
    span;
    chk(lo, (st.vsync_width + 1) * ln);
    chk(per, (st.frame_line_count + 1) * ln);
    step(60);
    chk(den, 1'b1);
    for (int m = 0; m < 4; m++) begin
      cfg[0].mode = dpi_mode_e'(m);
      cfg[0].rs_first = m[0];
      cfg[0].rw_enable = (m != 2);
      xfer(1'b0, 1'b0, 1, 1'b0);
      xfer(1'b0, 1'b1, 0, 1'b0);
    end
    xfer(1'b1, 1'b0, 3, 1'b1);
    xfer(1'b1, 1'b1, 0, 1'b0);
    // A write start with nothing queued is ignored
    rd = 1'b0;
    start = 1'b1;
    step;
    start = 1'b0;
    chk(busy, 1'b0);
    // Fill the queue until it refuses, then drain it in one burst
    wr_valid = 1'b1;
    n = 0;
    for (int i = 0; i < 20; i++) begin
      wr_data = 16'($random(seed));
      if (wr_ready === 1'b1) begin
        n++;
        wq.push_back(wr_data);
      end
      step;
    end
    wr_valid = 1'b0;
    chk(n, DPI_FIFO_D);
    chk(wr_ready, 1'b0);
    xfer(1'b1, 1'b0, 0, 1'b1);
    chk(wr_ready, 1'b1);
    // Reset in mid-transfer must deselect the panel and release the line
    wr(16'h00a5);
    wr_valid = 1'b0;
    start = 1'b1;
    step;
    start = 1'b0;
    step(20);
    nrst = 1'b0;
    step(3);
    chk({cs_n, busy, sclk, oe}, {DPI_CS_IDLE, 3'b010});
    wq = {};
    nrst = 1'b1;
    step(2);
    xfer(1'b0, 1'b0, 1, 1'b0);
    final_report;
  end
endmodule // tb_top
`default_nettype wire
